// file: logic/cmp_pkg.sv
// Purpose: Constants and types for the cell monitor protection block
// Assumes: 25 MHz REF_CLK, 32-bit classic Wishbone, byte addresses
// Notes:   Register words hold 4 to 16 bits in the low lanes
package cmp_pkg;
  // Timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int SAMPLE_HZ     = 32_000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int SCAN_MS       = 250;
  localparam int SCAN_CYCLES   = CLK_HZ / 1000 * SCAN_MS;
  localparam int TEMP_MS       = 2000;
  localparam int TEMP_SCANS    = TEMP_MS / SCAN_MS;
  // Register offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CTRL_A = 8'h04;
  localparam logic [7:0] ADR_CTRL_B = 8'h08;
  localparam logic [7:0] ADR_FSA    = 8'h0C;
  localparam logic [7:0] ADR_FSB    = 8'h10;
  localparam logic [7:0] ADR_FSC    = 8'h14;
  localparam logic [7:0] ADR_HIGH   = 8'h18;
  localparam logic [7:0] ADR_LOW    = 8'h1C;
  localparam logic [7:0] ADR_TEMP1  = 8'h20;
  localparam logic [7:0] ADR_TEMP2  = 8'h24;
  localparam logic [7:0] ADR_TEMP3  = 8'h28;
  localparam logic [7:0] ADR_PACK   = 8'h2C;
  // Field positions
  localparam int CA_TEMP_SEL = 3;
  localparam int CA_ADC_EN   = 4;
  localparam int CB_CHG      = 0;
  localparam int CB_DSG      = 1;
  localparam int CB_BYPASS   = 7;
  // Trip level framing
  localparam logic [1:0] HIGH_TOP = 2'h2;
  localparam logic [3:0] HIGH_BOT = 4'h8;
  localparam logic [1:0] LOW_TOP  = 2'h1;
  localparam logic [3:0] LOW_BOT  = 4'h0;
  localparam logic [13:0] LOW_MINQUAL = 14'h0400;
  // Defaults loaded on first NORMAL entry
  localparam logic [7:0] DEF_FSA  = 8'h00;
  localparam logic [7:0] DEF_FSB  = 8'h00;
  localparam logic [7:0] DEF_FSC  = 8'h11;
  localparam logic [7:0] DEF_HIGH = 8'hAC;
  localparam logic [7:0] DEF_LOW  = 8'h97;
  // Sticky fault flags, low bits of the status word
  typedef struct packed {
    logic uv;
    logic ov;
    logic discharge_short_fault;
    logic discharge_excess_current;
  } cmp_status_t;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_CELL = 2'b01,
    SC_TEMP = 2'b10
  } cmp_sched_t;
endpackage

// file: logic/cmp_top.sv
// Purpose: Scheduling, result storage and fault protection of a cell monitor
// Assumes: Converter and current comparators sit outside, synchronous to REF_CLK
// Notes:   Registers on classic Wishbone; status bits are write-one-to-clear
//
// Functional notes
// R1 - Temp select 1 stores thermistor results
// R2 - Temp select 0 measures die temperature
// R3 - New source appears within two seconds
// R4 - Temperature results are 14-bit codes
// R5 - Extra die results in second, third
// R6 - Pack result is 16-bit cell sum
// R7 - Full update with pack sum every 250 ms
// R8 - Temperature measured every two seconds
// R9 - Current comparators sampled 32 kHz, NORMAL only
// R10 - Over-threshold counter trips fault at delay
// R11 - Current limits from two setting registers
// R12 - Cell limits checked against 8-bit codes
// R13 - High level is 10, code, 1000
// R14 - Low level is 01, code, 0000
// R15 - Low check skipped below qualifier level
// R16 - Defaults on NORMAL entry, kept until reset
// R17 - Host rewrites limits at its start-up
// R18 - Cell checks need converter enable set
// R19 - Host forms codes from trimmed target
// R20 - Bypass bit skips cell fault timers
// R21 - High clears charge, others clear discharge
// R22 - Alert is OR of status bits
// R23 - Writing one clears a status bit
// R24 - Counter resets when current drops back
// R25 - Cell faults qualified by delay timers
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module cmp_top #(
  parameter int CELLS       = 5,
  parameter int SCAN_CYCLES = cmp_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  // Wishbone slave
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  // Power mode
  input  wire logic                  NORMAL_MODE,
  // Converter
  output logic                       CELL_START,
  input  wire logic                  CELL_VALID,
  input  wire logic [CELLS*14-1:0]   CELL_DATA,
  output logic                       TEMP_START,
  output logic                       TEMP_SEL_O,
  input  wire logic                  TEMP_VALID,
  input  wire logic [41:0]           TEMP_DATA,
  // Current comparators
  input  wire logic                  OCD_OVER,
  input  wire logic                  SCD_OVER,
  output logic      [3:0]            OCD_LEVEL,
  output logic      [2:0]            SCD_LEVEL,
  // Switches and alert
  output logic                       CHG_EN,
  output logic                       DSG_EN,
  output logic                       ALERT
);
  initial begin
    if (CELLS < 1 || CELLS > 15) $error("CELLS out of range");
    if (SCAN_CYCLES < 4) $error("SCAN_CYCLES too small");
    if (SCAN_CYCLES > 8388608) $error("SCAN_CYCLES beyond scan counter");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus
  cmp_pkg::cmp_status_t system_status_reg;
  cmp_pkg::cmp_status_t set_st;
  cmp_pkg::cmp_status_t clr_st;
  logic [7:0]  ctrl_a;
  logic [7:0]  system_control_b;
  logic [7:0]  fault_setting_a;
  logic [7:0]  fault_setting_b;
  logic [7:0]  fault_setting_c;
  logic [7:0]  high_cell_limit_code;
  logic [7:0]  low_cell_limit_code;
  logic [13:0] temp_result_first;
  logic [13:0] temp_result_second;
  logic [13:0] temp_result_third;
  logic [15:0] pack_sum_result;
  logic [15:0] next_pack;
  logic [31:0] next_rdata;
  logic        bus_req;
  logic        wr_lo;
  logic        normal_q;
  logic        loaded;
  logic        enter_normal;
  assign bus_req      = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_lo        = bus_req && WB_WE_I && WB_SEL_I[0];
  assign enter_normal = NORMAL_MODE && !normal_q;
  // Single-cycle answer; unmapped reads return zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req && !WB_WE_I) begin
        WB_DAT_O <= next_rdata;
      end
    end
  end
  always_comb begin
    next_rdata = 32'h0;
    case (WB_ADR_I)
      cmp_pkg::ADR_STATUS: next_rdata[3:0] = system_status_reg;
      cmp_pkg::ADR_CTRL_A: next_rdata[7:0] = ctrl_a;
      cmp_pkg::ADR_CTRL_B: next_rdata[7:0] = system_control_b;
      cmp_pkg::ADR_FSA:    next_rdata[7:0] = fault_setting_a;
      cmp_pkg::ADR_FSB:    next_rdata[7:0] = fault_setting_b;
      cmp_pkg::ADR_FSC:    next_rdata[7:0] = fault_setting_c;
      cmp_pkg::ADR_HIGH:   next_rdata[7:0] = high_cell_limit_code;
      cmp_pkg::ADR_LOW:    next_rdata[7:0] = low_cell_limit_code;
      cmp_pkg::ADR_TEMP1:  next_rdata[13:0] = temp_result_first;  // R4
      cmp_pkg::ADR_TEMP2:  next_rdata[13:0] = temp_result_second;
      cmp_pkg::ADR_TEMP3:  next_rdata[13:0] = temp_result_third;
      cmp_pkg::ADR_PACK:   next_rdata[15:0] = pack_sum_result;
      default:             next_rdata = 32'h0;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      normal_q <= 1'b0;
    end else begin
      normal_q <= NORMAL_MODE;
    end
  end
  // Defaults only once per power-on; host values survive mode changes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      loaded               <= 1'b0;
      fault_setting_a      <= 8'h00;
      fault_setting_b      <= 8'h00;
      fault_setting_c      <= 8'h00;
      high_cell_limit_code <= 8'h00;
      low_cell_limit_code  <= 8'h00;
    end else if (NORMAL_MODE && !loaded) begin
      loaded               <= 1'b1;                   // R16
      fault_setting_a      <= cmp_pkg::DEF_FSA;
      fault_setting_b      <= cmp_pkg::DEF_FSB;
      fault_setting_c      <= cmp_pkg::DEF_FSC;
      high_cell_limit_code <= cmp_pkg::DEF_HIGH;
      low_cell_limit_code  <= cmp_pkg::DEF_LOW;
    end else if (wr_lo) begin
      case (WB_ADR_I)
        cmp_pkg::ADR_FSA:  fault_setting_a      <= WB_DAT_I[7:0];  // R11
        cmp_pkg::ADR_FSB:  fault_setting_b      <= WB_DAT_I[7:0];
        cmp_pkg::ADR_FSC:  fault_setting_c      <= WB_DAT_I[7:0];
        cmp_pkg::ADR_HIGH: high_cell_limit_code <= WB_DAT_I[7:0];  // R12
        cmp_pkg::ADR_LOW:  low_cell_limit_code  <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end
  // Converter enable is forced on at each NORMAL entry
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_a <= 8'h00;
    end else begin
      if (wr_lo && WB_ADR_I == cmp_pkg::ADR_CTRL_A) begin
        ctrl_a <= WB_DAT_I[7:0];
      end
      if (enter_normal) begin
        ctrl_a[cmp_pkg::CA_ADC_EN] <= 1'b1;
      end
    end
  end
  // Fault clears win over a host write in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      system_control_b <= 8'h00;
    end else begin
      if (wr_lo && WB_ADR_I == cmp_pkg::ADR_CTRL_B) begin
        system_control_b <= WB_DAT_I[7:0];
      end
      if (set_st.ov) begin
        system_control_b[cmp_pkg::CB_CHG] <= 1'b0;  // R21
      end
      if (set_st.uv || set_st.discharge_excess_current || set_st.discharge_short_fault) begin
        system_control_b[cmp_pkg::CB_DSG] <= 1'b0;  // R21
      end
    end
  end
  // Set beats clear when both land together
  assign clr_st = (wr_lo && WB_ADR_I == cmp_pkg::ADR_STATUS) ? WB_DAT_I[3:0] : 4'h0;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      system_status_reg <= 4'h0;
    end else begin
      system_status_reg <= (system_status_reg & ~clr_st) | set_st;  // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ALERT     <= 1'b0;
      CHG_EN    <= 1'b0;
      DSG_EN    <= 1'b0;
      OCD_LEVEL <= 4'h0;
      SCD_LEVEL <= 3'h0;
    end else begin
      ALERT     <= |((system_status_reg & ~clr_st) | set_st);  // R22
      CHG_EN    <= system_control_b[cmp_pkg::CB_CHG] && !set_st.ov;
      DSG_EN    <= system_control_b[cmp_pkg::CB_DSG]
                   && !(set_st.uv || set_st.discharge_excess_current || set_st.discharge_short_fault);
      OCD_LEVEL <= fault_setting_b[3:0];  // R11
      SCD_LEVEL <= fault_setting_a[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master scheduler
  cmp_pkg::cmp_sched_t state;
  logic [22:0] scan_cnt;
  logic [2:0]  temp_cnt;
  logic        scan_tick;
  assign scan_tick = NORMAL_MODE && scan_cnt == 23'(SCAN_CYCLES - 1);
  always_ff @(posedge REF_CLK) begin
    if (RST || !NORMAL_MODE || scan_tick) begin
      scan_cnt <= 23'h0;
    end else begin
      scan_cnt <= scan_cnt + 23'h1;  // R7
    end
  end
  // A slow converter simply costs the next tick
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state      <= cmp_pkg::SC_IDLE;
      temp_cnt   <= 3'h0;
      CELL_START <= 1'b0;
      TEMP_START <= 1'b0;
      TEMP_SEL_O <= 1'b0;
    end else begin
      CELL_START <= 1'b0;
      TEMP_START <= 1'b0;
      case (state)
        cmp_pkg::SC_IDLE: begin
          if (scan_tick) begin
            CELL_START <= 1'b1;  // R7
            state      <= cmp_pkg::SC_CELL;
          end
        end
        cmp_pkg::SC_CELL: begin
          if (CELL_VALID) begin
            temp_cnt <= (temp_cnt == 3'(cmp_pkg::TEMP_SCANS - 1)) ? 3'h0 : temp_cnt + 3'h1;
            if (temp_cnt == 3'h0) begin
              TEMP_START <= 1'b1;  // R8
              TEMP_SEL_O <= ctrl_a[cmp_pkg::CA_TEMP_SEL];  // R3
              state      <= cmp_pkg::SC_TEMP;
            end else begin
              state <= cmp_pkg::SC_IDLE;
            end
          end
        end
        cmp_pkg::SC_TEMP: begin
          if (TEMP_VALID) begin
            state <= cmp_pkg::SC_IDLE;
          end
        end
        default: state <= cmp_pkg::SC_IDLE;
      endcase
    end
  end
  // Thermistors or die sensors, by the source latched at start
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      temp_result_first  <= 14'h0;
      temp_result_second <= 14'h0;
      temp_result_third  <= 14'h0;
    end else if (TEMP_VALID && state == cmp_pkg::SC_TEMP) begin
      temp_result_first  <= TEMP_DATA[13:0];   // R1 R2
      temp_result_second <= TEMP_DATA[27:14];  // R5
      temp_result_third  <= TEMP_DATA[41:28];  // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cell checks and pack sum
  logic [13:0] high_level;
  logic [13:0] low_level;
  logic [19:0] cell_sum;
  logic        high_hit;
  logic        low_hit;
  logic        cell_done;
  logic        bypass;
  logic [2:0]  high_cnt;
  logic [2:0]  low_cnt;
  assign high_level = {cmp_pkg::HIGH_TOP, high_cell_limit_code, cmp_pkg::HIGH_BOT};  // R13
  assign low_level  = {cmp_pkg::LOW_TOP, low_cell_limit_code, cmp_pkg::LOW_BOT};     // R14
  assign cell_done  = CELL_VALID && state == cmp_pkg::SC_CELL;
  assign bypass     = system_control_b[cmp_pkg::CB_BYPASS];
  always_comb begin
    logic [13:0] c;
    c        = 14'h0;
    cell_sum = 20'h0;
    high_hit = 1'b0;
    low_hit  = 1'b0;
    for (int i = 0; i < CELLS; i++) begin
      c        = CELL_DATA[i*14 +: 14];
      cell_sum = cell_sum + 20'(c);  // R6
      if (c > high_level) high_hit = 1'b1;  // R12
      if (c < low_level && c >= cmp_pkg::LOW_MINQUAL) low_hit = 1'b1;  // R15
    end
    next_pack = cell_sum[17:2];  // R6
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pack_sum_result <= 16'h0;
    end else if (cell_done) begin
      pack_sum_result <= next_pack;  // R7
    end
  end
  // Timers count qualifying readings, one per scan
  always_ff @(posedge REF_CLK) begin
    if (RST || !ctrl_a[cmp_pkg::CA_ADC_EN]) begin
      high_cnt <= 3'h0;
      low_cnt  <= 3'h0;
    end else if (cell_done) begin
      high_cnt <= (high_hit && high_cnt != fault_setting_c[2:0]) ? high_cnt + 3'h1 : 3'h0;
      low_cnt  <= (low_hit && low_cnt != fault_setting_c[6:4]) ? low_cnt + 3'h1 : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Current comparators
  logic [9:0] smp_cnt;
  logic       smp_tick;
  logic [7:0] ocd_cnt;
  logic [7:0] ocd_target;
  logic [3:0] scd_cnt;
  logic [3:0] scd_target;
  assign smp_tick   = smp_cnt == 10'(cmp_pkg::SAMPLE_CYCLES - 1);
  assign ocd_target = {fault_setting_b[6:4], 5'h1F};  // R11
  assign scd_target = {fault_setting_a[4:3], 2'h3};
  always_ff @(posedge REF_CLK) begin
    if (RST || smp_tick) begin
      smp_cnt <= 10'h0;
    end else begin
      smp_cnt <= smp_cnt + 10'h1;  // R9
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST || !NORMAL_MODE) begin
      ocd_cnt <= 8'h0;  // R9
      scd_cnt <= 4'h0;
    end else if (smp_tick) begin
      ocd_cnt <= !OCD_OVER ? 8'h0 : (ocd_cnt == ocd_target) ? ocd_cnt : ocd_cnt + 8'h1;  // R24
      scd_cnt <= !SCD_OVER ? 4'h0 : (scd_cnt == scd_target) ? scd_cnt : scd_cnt + 4'h1;  // R24
    end
  end
  always_comb begin
    set_st     = 4'h0;
    set_st.discharge_excess_current = NORMAL_MODE && smp_tick && OCD_OVER && ocd_cnt == ocd_target;  // R10
    set_st.discharge_short_fault = NORMAL_MODE && smp_tick && SCD_OVER && scd_cnt == scd_target;  // R10
    set_st.ov  = cell_done && ctrl_a[cmp_pkg::CA_ADC_EN] && high_hit
                 && (bypass || high_cnt == fault_setting_c[2:0]);  // R18 R20 R25
    set_st.uv  = cell_done && ctrl_a[cmp_pkg::CA_ADC_EN] && low_hit
                 && (bypass || low_cnt == fault_setting_c[6:4]);  // R18 R20 R25
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_alert_or_status: assert property (##1 ALERT == (|system_status_reg))  // R22
    else $error("Alert differs from status OR");
  a_status_w1c: assert property (!(wr_lo && WB_ADR_I == cmp_pkg::ADR_STATUS)
      |=> ($past(system_status_reg) & ~system_status_reg) == 4'h0)  // R23
    else $error("Status bit fell without write");
  a_high_clears_chg: assert property ($rose(system_status_reg.ov) |-> !CHG_EN)  // R21
    else $error("Charge enable kept on high fault");
  a_low_clears_dsg: assert property ($rose(system_status_reg.uv) |-> !DSG_EN)  // R21
    else $error("Discharge enable kept on low fault");
  a_ocd_delay_met: assert property ($rose(system_status_reg.discharge_excess_current)
      |-> $past(ocd_cnt) == $past(ocd_target) && $past(OCD_OVER))  // R10
    else $error("Current fault before delay");
  a_ocd_drop_reset: assert property (smp_tick && !OCD_OVER |=> ocd_cnt == 8'h0)  // R24
    else $error("Counter kept after current dropped");
  a_cell_needs_adc: assert property ($rose(system_status_reg.ov)
      |-> $past(ctrl_a[cmp_pkg::CA_ADC_EN]) && $past(cell_done))  // R18
    else $error("Cell fault without converter enable");
  a_pack_sum_load: assert property (cell_done |=> pack_sum_result == $past(next_pack))  // R6
    else $error("Pack sum not stored");
  a_temp_every_8: assert property (TEMP_START |=> !TEMP_START [*8])  // R8
    else $error("Temperature started too often");
  a_defaults_load: assert property ($rose(loaded) |-> high_cell_limit_code == cmp_pkg::DEF_HIGH)  // R16
    else $error("Defaults not loaded");
endmodule  // cmp_top

// file: tb/cmp_conv_model.sv
// Purpose: Converter stand-in that answers cell and temperature requests
// Assumes: Requests are one-cycle pulses; latency 1..16 cycles from lat
// Notes:   Idle data lines toggle every cycle so stale values never match
`timescale 1ns/100ps
module cmp_conv_model #(
  parameter int CELLS = 5
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Requests
  input  wire logic                cell_start,
  input  wire logic                temp_start,
  input  wire logic                temp_sel,
  input  wire logic [3:0]          lat,
  // Analog sources
  input  wire logic [CELLS*14-1:0] cells_in,
  input  wire logic [41:0]         therm_in,
  input  wire logic [41:0]         die_in,
  // Answers
  output logic                     cell_valid,
  output logic [CELLS*14-1:0]      cell_data,
  output logic                     temp_valid,
  output logic [41:0]              temp_data
);
  logic [4:0]          cnt_c;
  logic [4:0]          cnt_t;
  logic [CELLS*14-1:0] hold_c;
  ////////////////////////////////////////////////////////////////////////////
  // Cell set: inputs latched at the request, like a real sampling window
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_c      <= 5'h00;
      cell_valid <= 1'b0;
      cell_data  <= '0;
    end else begin
      cell_valid <= 1'b0;
      cell_data  <= ~cell_data;
      if (cell_start) begin
        cnt_c  <= {1'b0, lat} + 5'h01;
        hold_c <= cells_in;
      end else if (cnt_c != 5'h00) begin
        cnt_c <= cnt_c - 5'h01;
        if (cnt_c == 5'h01) begin
          cell_valid <= 1'b1;
          cell_data  <= hold_c;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Temperatures: source chosen late, select settles with the request
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_t      <= 5'h00;
      temp_valid <= 1'b0;
      temp_data  <= '0;
    end else begin
      temp_valid <= 1'b0;
      temp_data  <= ~temp_data;
      if (temp_start) begin
        cnt_t <= {1'b0, lat} + 5'h01;
      end else if (cnt_t != 5'h00) begin
        cnt_t <= cnt_t - 5'h01;
        if (cnt_t == 5'h01) begin
          temp_valid <= 1'b1;
          temp_data  <= temp_sel ? therm_in : die_in;
        end
      end
    end
  end
endmodule // cmp_conv_model

// file: tb/cmp_top_tb.sv
// Purpose: Self-checking bench for the cell monitor protection block
// Assumes: Scan period shortened to 200 cycles
// Notes:   All waits bounded; watchdog cuts a hang
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module cmp_top_tb;
  localparam int CELLS = 5;
  localparam int SMP   = cmp_pkg::SAMPLE_CYCLES;
  logic                ref_clk, rst, cyc, stb, we, normal, ack;
  logic                c_start, c_valid, t_start, t_sel, t_valid;
  logic                ocd_over, scd_over, chg_en, dsg_en, alert;
  logic [7:0]          adr, code;
  logic [31:0]         wdat, rdat, q;
  logic [3:0]          lat, ocd_lvl;
  logic [2:0]          scd_lvl;
  logic [13:0]         lvl;
  logic [CELLS*14-1:0] cells, c_data;
  logic [41:0]         therm, die, t_data;
  integer              seed;
  int                  err_count, n_checks, vcnt, gap;
  cmp_top #(.CELLS(CELLS), .SCAN_CYCLES(200)) dut (
    .REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .NORMAL_MODE(normal), .CELL_START(c_start), .CELL_VALID(c_valid), .CELL_DATA(c_data),
    .TEMP_START(t_start), .TEMP_SEL_O(t_sel), .TEMP_VALID(t_valid), .TEMP_DATA(t_data),
    .OCD_OVER(ocd_over), .SCD_OVER(scd_over), .OCD_LEVEL(ocd_lvl), .SCD_LEVEL(scd_lvl),
    .CHG_EN(chg_en), .DSG_EN(dsg_en), .ALERT(alert));
  cmp_conv_model #(.CELLS(CELLS)) conv (
    .clk(ref_clk), .rst(rst), .cell_start(c_start), .temp_start(t_start), .temp_sel(t_sel),
    .lat(lat), .cells_in(cells), .therm_in(therm), .die_in(die), .cell_valid(c_valid),
    .cell_data(c_data), .temp_valid(t_valid), .temp_data(t_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Classic cycle: hold until ack seen at an edge, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    `CHK(ack, 1'b1, "ack")
    cyc <= 1'b0;
    stb <= 1'b0;
    lat <= 4'($random(seed));
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 8'h00);
    `CHK(q, e, m)
  endtask
  task automatic await(input logic which);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((which ? t_start : c_valid) !== 1'b1 && n < 4000);
    `CHK(n < 4000, 1'b1, "wait")
  endtask
  task automatic scans(input int k);
    repeat (k) await(1'b0);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic calm;
    for (int i = 0; i < CELLS; i++) begin
      cells[i*14 +: 14] <= 14'h2000 | 14'($random(seed) & 32'h3FF);
    end
  endtask
  function automatic logic [15:0] pack_of(input logic [CELLS*14-1:0] v);
    logic [16:0] s;
    s = '0;
    for (int i = 0; i < CELLS; i++) begin
      s += 17'(v[i*14 +: 14]);
    end
    return 16'(s >> 2);
  endfunction
  function automatic logic [7:0] trip_code(input logic [13:0] full);
    return full[11:4];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Scans between temperature requests
  always @(posedge ref_clk) begin
    if (c_valid === 1'b1) vcnt++;
    if (t_start === 1'b1) begin
      gap = vcnt;
      vcnt = 0;
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
  initial begin
    seed = 32'hab77;
    rst = 1'b1;
    {cyc, stb, we, normal, ocd_over, scd_over} = 6'h00;
    adr = 8'h00;
    wdat = 32'h0;
    lat = 4'h2;
    cells = '0;
    therm = {14'h0ABC, 14'h1234, 14'h2345};
    die = {14'h3111, 14'h2222, 14'h1333};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    calm();
    @(posedge ref_clk);
    rd(cmp_pkg::ADR_FSC, 32'h0, "fsc pre");
    normal <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(cmp_pkg::ADR_FSC, {24'h0, cmp_pkg::DEF_FSC}, "fsc def");
    rd(cmp_pkg::ADR_HIGH, {24'h0, cmp_pkg::DEF_HIGH}, "high def");
    rd(cmp_pkg::ADR_LOW, {24'h0, cmp_pkg::DEF_LOW}, "low def");
    rd(8'h40, 32'h0, "unmapped");
    bus(1'b1, cmp_pkg::ADR_CTRL_B, 8'h83);
    scans(2);
    rd(cmp_pkg::ADR_PACK, {16'h0, pack_of(cells)}, "pack");
    `CHK({chg_en, dsg_en, alert}, 3'b110, "sw on")
    $display("test defaults done");
    code = trip_code(14'h2800 | 14'($random(seed) & 32'h7FF));
    lvl = {cmp_pkg::HIGH_TOP, code, cmp_pkg::HIGH_BOT};
    bus(1'b1, cmp_pkg::ADR_HIGH, code);
    cells[13:0] <= lvl;
    scans(2);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "ov edge");
    await(1'b0);
    cells[13:0] <= lvl + 14'h1;
    scans(1);
    rd(cmp_pkg::ADR_STATUS, 32'h4, "ov hit");
    `CHK({chg_en, dsg_en, alert}, 3'b011, "ov sw")
    cells[13:0] <= 14'h2000;
    scans(2);
    bus(1'b1, cmp_pkg::ADR_STATUS, 8'h00);
    rd(cmp_pkg::ADR_STATUS, 32'h4, "w0 keep");
    bus(1'b1, cmp_pkg::ADR_STATUS, 8'h04);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "w1 clr");
    `CHK(alert, 1'b0, "alert low")
    $display("test high cell done");
    bus(1'b1, cmp_pkg::ADR_CTRL_B, 8'h03);
    code = trip_code(14'h1000 | 14'($random(seed) & 32'hFFF));
    lvl = {cmp_pkg::LOW_TOP, code, cmp_pkg::LOW_BOT};
    bus(1'b1, cmp_pkg::ADR_LOW, code);
    cells[27:14] <= cmp_pkg::LOW_MINQUAL - 14'h1;
    scans(2);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "uv skip");
    await(1'b0);
    cells[27:14] <= lvl - 14'h1;
    scans(1);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "uv delay");
    scans(1);
    rd(cmp_pkg::ADR_STATUS, 32'h8, "uv hit");
    `CHK({chg_en, dsg_en}, 2'b10, "uv sw")
    bus(1'b1, cmp_pkg::ADR_CTRL_A, 8'h08);
    bus(1'b1, cmp_pkg::ADR_STATUS, 8'h0F);
    scans(2);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "adc off");
    calm();
    normal <= 1'b0;
    repeat (5) @(posedge ref_clk);
    normal <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(cmp_pkg::ADR_LOW, {24'h0, code}, "kept");
    bus(1'b1, cmp_pkg::ADR_CTRL_A, 8'h18);
    $display("test low cell done");
    await(1'b1);
    `CHK(t_sel, 1'b1, "sel therm")
    repeat (25) @(posedge ref_clk);
    rd(cmp_pkg::ADR_TEMP1, {18'h0, therm[13:0]}, "therm");
    bus(1'b1, cmp_pkg::ADR_CTRL_A, 8'h10);
    await(1'b1);
    `CHK(t_sel, 1'b0, "sel die")
    repeat (25) @(posedge ref_clk);
    `CHK(gap, cmp_pkg::TEMP_SCANS, "temp gap")
    rd(cmp_pkg::ADR_TEMP2, {18'h0, die[27:14]}, "die2");
    rd(cmp_pkg::ADR_TEMP3, {18'h0, die[41:28]}, "die3");
    $display("test temperature done");
    bus(1'b1, cmp_pkg::ADR_CTRL_B, 8'h83);
    code = 8'($random(seed));
    bus(1'b1, cmp_pkg::ADR_FSA, {5'h00, code[2:0]});
    bus(1'b1, cmp_pkg::ADR_FSB, {4'h0, code[6:3]});
    `CHK(scd_lvl, code[2:0], "scd lvl")
    `CHK(ocd_lvl, code[6:3], "ocd lvl")
    scd_over <= 1'b1;
    repeat (2 * SMP) @(posedge ref_clk);
    scd_over <= 1'b0;
    repeat (SMP) @(posedge ref_clk);
    rd(cmp_pkg::ADR_STATUS, 32'h0, "scd glitch");
    scd_over <= 1'b1;
    repeat (6 * SMP) @(posedge ref_clk);
    scd_over <= 1'b0;
    rd(cmp_pkg::ADR_STATUS, 32'h2, "scd trip");
    `CHK({chg_en, dsg_en, alert}, 3'b101, "scd sw")
    bus(1'b1, cmp_pkg::ADR_STATUS, 8'h02);
    bus(1'b1, cmp_pkg::ADR_CTRL_B, 8'h83);
    ocd_over <= 1'b1;
    repeat (34 * SMP) @(posedge ref_clk);
    ocd_over <= 1'b0;
    rd(cmp_pkg::ADR_STATUS, 32'h1, "ocd trip");
    `CHK(dsg_en, 1'b0, "ocd sw")
    $display("test current done");
    complete_run();
  end
endmodule // cmp_top_tb
